// ### shared/cfsa_pkg.sv
/*
  package for the cpu flags, segment addressing and queue status block:
  flag bit positions, register indexes, segment selects, reference kinds,
  queue status codes and reset values.
  assumes a single clock domain and a synchronous active-high reset.
*/
// Behaviour
// (RULE1) physical address is segment base shifted left four plus offset, 20 bits
// (RULE2) each segment spans at most 64K bytes via a 16-bit offset
// (RULE3) implied segment is used unless an override prefix names another one
// (RULE4) code for fetch and immediates, stack for push pop and frame base, extra for dest strings
// (RULE5) bit 0 set on carry out of or borrow into the result msb; byte add takes bit 8 of the 16-bit sum instead
// (RULE6) bit 2 set when low result byte has an even count of ones
// (RULE7) bit 4 set on carry or borrow at the low nibble
// (RULE8) bit 6 set when the result is zero
// (RULE9) bit 7 copies the result msb
// (RULE10) bit 8 set raises single-step trap after next instruction; entry clears it
// (RULE11) maskable interrupts are taken only while bit 9 is set
// (RULE12) bit 10 set makes string index step down, clear makes it step up
// (RULE13) bit 11 set when signed result does not fit destination width
// (RULE14) flags word is 16 bits; six status bits and three control bits
// (RULE15) eight 16-bit general registers, four also split into byte halves
// (RULE16) instruction pointer holds offset of next sequential instruction in code segment
// (RULE17) one 32-bit pointer can load both segment base and offset; the code keeps the offset only for the code segment, into the ip
// (RULE18) queue status: 00 idle, 01 first byte, 11 next byte, 10 flush
// (RULE19) in queue mode the latch enable and write pins carry queue status
// (RULE20) read pin held low after reset selects queue mode; sampled after reset
// (RULE21) write strobe low marks write data; floats during hold and reset
// (RULE22) segment plus offset sum wraps at 20 bits
// (RULE23) unassigned flag bits hold fixed values and ignore writes
package cfsa_pkg;

  // flag bit positions
  localparam int unsigned FLAG_CARRY_POS = 0;
  localparam int unsigned FLAG_PARITY_POS = 2;
  localparam int unsigned FLAG_NIBBLE_POS = 4;
  localparam int unsigned FLAG_ZERO_POS = 6;
  localparam int unsigned FLAG_SIGN_POS = 7;
  localparam int unsigned FLAG_STEP_POS = 8;
  localparam int unsigned FLAG_IRQEN_POS = 9;
  localparam int unsigned FLAG_DIR_POS = 10;
  localparam int unsigned FLAG_OVF_POS = 11;

  // writable bits of the flags word, and the fixed value of the rest
  localparam logic [15:0] FLAGS_WR_MASK = 16'h0fd5;
  localparam logic [15:0] FLAGS_FIXED = 16'hf002;
  localparam logic [15:0] FLAGS_RESET = 16'hf002;

  // address geometry
  localparam int unsigned SEG_SHIFT = 4;
  localparam int unsigned PHYS_AW = 20;

  // register file bus: indexes, data is 16 bits
  localparam logic [4:0] REG_GEN0 = 5'h00; // 0..7 general words
  localparam logic [4:0] REG_SEG0 = 5'h08; // 8..11 segments
  localparam logic [4:0] REG_IP = 5'h0c;
  localparam logic [4:0] REG_FLAGS = 5'h0d;
  localparam logic [4:0] REG_MODE = 5'h0e; // bit0 queue mode, read only
  localparam logic [4:0] REG_BYTE0 = 5'h10; // 0x10..0x17 byte halves
  localparam logic [15:0] IP_RESET = 16'h0000;
  localparam logic [15:0] CODE_SEG_RESET = 16'hffff;

  // segment selects
  typedef enum logic [1:0] {
    CFSA_SEG_EXTRA = 2'b00,
    CFSA_SEG_CODE = 2'b01,
    CFSA_SEG_STACK = 2'b10,
    CFSA_SEG_DATA = 2'b11
  } cfsa_seg_t;

  // kind of memory reference, for implied segment choice
  typedef enum logic [1:0] {
    CFSA_REF_FETCH = 2'b00,
    CFSA_REF_STACK = 2'b01,
    CFSA_REF_DEST_STR = 2'b10,
    CFSA_REF_DATA = 2'b11
  } cfsa_ref_t;

  // alu operations; all but pass update flags
  typedef enum logic [1:0] {
    CFSA_OP_ADD = 2'b00,
    CFSA_OP_SUB = 2'b01,
    CFSA_OP_LOGIC = 2'b10,
    CFSA_OP_PASS = 2'b11
  } cfsa_op_t;

  // queue status codes {high, low}
  typedef enum logic [1:0] {
    CFSA_Q_IDLE = 2'b00,
    CFSA_Q_FIRST = 2'b01,
    CFSA_Q_FLUSH = 2'b10,
    CFSA_Q_NEXT = 2'b11
  } cfsa_qs_t;

endpackage : cfsa_pkg

// ### logic/cfsa_core.sv
/*
  execution core state: general, segment and pointer registers, flags word
  with result flag generation, segmented address generation, string index
  stepping, interrupt gating and queue status / strobe pin muxing.
  assumes the sequencer around it drives the event inputs one cycle each,
  synchronous to CLK, and never asserts a register write and read together.
*/
`timescale 1ns/1ps
`default_nettype none
module cfsa_core
  import cfsa_pkg::*;
#(
  parameter int unsigned DW = 16
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // register port
  input wire logic [4:0] REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [15:0] REG_RDATA,
  // alu result update
  input wire logic ALU_EN,
  input wire logic [1:0] ALU_OP,
  input wire logic ALU_BYTE,
  input wire logic [15:0] ALU_A,
  input wire logic [15:0] ALU_B,
  input wire logic ALU_CIN,
  input wire logic [2:0] ALU_DEST,
  // address generation
  input wire logic ADDR_EN,
  input wire logic [1:0] REF_KIND,
  input wire logic USE_FRAME_BASE,
  input wire logic OVR_VALID,
  input wire logic [1:0] OVR_SEG,
  input wire logic [15:0] ADDR_OFFSET,
  output logic [19:0] PHYS_ADDR,
  // instruction pointer and far pointer load
  input wire logic IP_ADVANCE,
  input wire logic [2:0] IP_STEP,
  input wire logic FAR_LOAD,
  input wire logic [31:0] FAR_PTR,
  input wire logic [1:0] FAR_SEG,
  // string stepping
  input wire logic STR_STEP,
  input wire logic STR_WORD,
  // instruction boundary and interrupts
  input wire logic INSTR_DONE,
  input wire logic MASK_IRQ,
  output logic TRAP_STEP,
  output logic TAKE_IRQ,
  // queue activity and bus strobes
  input wire logic [1:0] QUEUE_EVENT,
  input wire logic BUS_HOLD,
  input wire logic ALE_REQ,
  input wire logic WRITE_REQ,
  input wire logic READ_PIN_I,
  output logic ALE_QS0,
  output logic WR_QS1_O,
  output logic WR_QS1_OE
);

  logic [15:0] gen_q [8]; // accum, count, data_ext, base, sp, frame_base, src, dest
  logic [15:0] seg_q [4];
  logic [15:0] ip_q;
  logic [15:0] flags_q;
  logic queue_mode_q;
  logic strap_done_q;
  logic step_pend_q;

  // byte-half index decode: 0..3 low halves, 4..7 high halves of words 0..3
  function automatic logic [15:0] cfsa_byte_merge(input logic [15:0] w, input logic hi,
                                                  input logic [7:0] b);
    cfsa_byte_merge = hi ? {b, w[7:0]} : {w[15:8], b};
  endfunction : cfsa_byte_merge

  // implied or overriding segment for a reference
  function automatic cfsa_seg_t cfsa_pick_seg(input logic [1:0] kind, input logic fb,
                                              input logic ov, input logic [1:0] os);
    cfsa_seg_t s;
    s = CFSA_SEG_DATA;
    if (kind == CFSA_REF_FETCH) begin
      s = CFSA_SEG_CODE; // RULE4
    end else if (kind == CFSA_REF_STACK || fb) begin
      s = CFSA_SEG_STACK; // RULE4
    end else if (kind == CFSA_REF_DEST_STR) begin
      s = CFSA_SEG_EXTRA; // RULE4
    end
    // fetches cannot be overridden; data references can
    if (ov && kind != CFSA_REF_FETCH) begin
      s = cfsa_seg_t'(os); // RULE3
    end
    cfsa_pick_seg = s;
  endfunction : cfsa_pick_seg

  // alu result and flag derivation
  logic [16:0] sum;
  logic [4:0] nib;
  logic [15:0] res;
  logic msb, cout, ovf;
  always_comb begin
    sum = 17'h00000;
    nib = 5'h00;
    case (ALU_OP)
      CFSA_OP_ADD: begin
        sum = {1'b0, ALU_A} + {1'b0, ALU_B} + {16'h0000, ALU_CIN};
        nib = {1'b0, ALU_A[3:0]} + {1'b0, ALU_B[3:0]} + {4'h0, ALU_CIN};
      end
      CFSA_OP_SUB: begin
        sum = {1'b0, ALU_A} - {1'b0, ALU_B} - {16'h0000, ALU_CIN};
        nib = {1'b0, ALU_A[3:0]} - {1'b0, ALU_B[3:0]} - {4'h0, ALU_CIN};
      end
      CFSA_OP_LOGIC: sum = {1'b0, ALU_A & ALU_B};
      default: sum = {1'b0, ALU_B};
    endcase
    res = ALU_BYTE ? {8'h00, sum[7:0]} : sum[15:0];
    msb = ALU_BYTE ? res[7] : res[15];
    // carry out of the msb: bit 8 of the full 16-bit sum for byte add, a byte compare gives the borrow for sub
    if (ALU_BYTE) begin
      cout = ((ALU_OP == CFSA_OP_SUB) ? (ALU_A[7:0] < ALU_B[7:0] ||
              (ALU_A[7:0] == ALU_B[7:0] && ALU_CIN)) : sum[8]);
    end else begin
      cout = sum[16];
    end
    if (ALU_OP == CFSA_OP_ADD) begin
      ovf = ALU_BYTE ? (ALU_A[7] == ALU_B[7] && msb != ALU_A[7])
                     : (ALU_A[15] == ALU_B[15] && msb != ALU_A[15]);
    end else if (ALU_OP == CFSA_OP_SUB) begin
      ovf = ALU_BYTE ? (ALU_A[7] != ALU_B[7] && msb != ALU_A[7])
                     : (ALU_A[15] != ALU_B[15] && msb != ALU_A[15]);
    end else begin
      ovf = 1'b0;
    end
  end

  // next flags word from an alu update
  logic [15:0] alu_flags;
  always_comb begin
    alu_flags = flags_q;
    if (ALU_OP[1] == 1'b0) begin
      alu_flags[FLAG_CARRY_POS] = cout; // RULE5
      alu_flags[FLAG_NIBBLE_POS] = nib[4]; // RULE7
      alu_flags[FLAG_OVF_POS] = ovf; // RULE13
    end else if (ALU_OP == CFSA_OP_LOGIC) begin
      alu_flags[FLAG_CARRY_POS] = 1'b0; // RULE5
      alu_flags[FLAG_OVF_POS] = 1'b0; // RULE13
    end
    if (ALU_OP != CFSA_OP_PASS) begin
      alu_flags[FLAG_PARITY_POS] = ~^res[7:0]; // RULE6
      alu_flags[FLAG_ZERO_POS] = (res == 16'h0000); // RULE8
      alu_flags[FLAG_SIGN_POS] = msb; // RULE9
    end
  end

  // a trap is pending when the step flag was set at the previous boundary
  logic trap_now;
  assign trap_now = INSTR_DONE && step_pend_q;

  // flags register: software write, alu update, trap entry
  always_ff @(posedge CLK) begin
    if (RESET) begin
      flags_q <= FLAGS_RESET;
    end else begin
      if (REG_WR && REG_ADDR == REG_FLAGS) begin
        flags_q <= (REG_WDATA & FLAGS_WR_MASK) | FLAGS_FIXED; // RULE14 RULE23
      end else if (ALU_EN) begin
        flags_q <= (alu_flags & FLAGS_WR_MASK) | FLAGS_FIXED; // RULE14
      end
      if (trap_now) begin
        flags_q[FLAG_STEP_POS] <= 1'b0; // RULE10
      end
    end
  end

  // step trap: armed when an instruction completes with the flag set,
  // fires after the following one so the setting instruction is not trapped
  always_ff @(posedge CLK) begin
    if (RESET) begin
      step_pend_q <= 1'b0;
      TRAP_STEP <= 1'b0;
      TAKE_IRQ <= 1'b0;
    end else begin
      if (INSTR_DONE) begin
        step_pend_q <= flags_q[FLAG_STEP_POS] && !trap_now; // RULE10
      end
      TRAP_STEP <= trap_now; // RULE10
      TAKE_IRQ <= INSTR_DONE && MASK_IRQ && flags_q[FLAG_IRQEN_POS]; // RULE11
    end
  end

  // general registers with byte-half access, alu writeback and string stepping
  logic [15:0] str_delta;
  assign str_delta = STR_WORD ? 16'h0002 : 16'h0001;
  generate
    for (genvar g = 0; g < 8; g++) begin : g_gen
      always_ff @(posedge CLK) begin
        if (RESET) begin
          gen_q[g] <= 16'h0000;
        end else if (REG_WR && REG_ADDR == REG_GEN0 + 5'(g)) begin
          gen_q[g] <= REG_WDATA; // RULE15
        end else if (g < 4 && REG_WR && REG_ADDR[4:3] == 2'b10 && REG_ADDR[1:0] == 2'(g)) begin
          gen_q[g] <= cfsa_byte_merge(gen_q[g], REG_ADDR[2], REG_WDATA[7:0]); // RULE15
        end else if (ALU_EN && ALU_OP != CFSA_OP_PASS && ALU_DEST == 3'(g)) begin
          gen_q[g] <= ALU_BYTE ? {gen_q[g][15:8], res[7:0]} : res; // RULE15
        end else if (STR_STEP && (g == 6 || g == 7)) begin
          // source and destination index step together
          gen_q[g] <= flags_q[FLAG_DIR_POS] ? gen_q[g] - str_delta
                                            : gen_q[g] + str_delta; // RULE12
        end
      end
    end
  endgenerate

  // segment registers, loaded by software or from a far pointer
  generate
    for (genvar s = 0; s < 4; s++) begin : g_seg
      always_ff @(posedge CLK) begin
        if (RESET) begin
          seg_q[s] <= (s == CFSA_SEG_CODE) ? CODE_SEG_RESET : 16'h0000;
        end else if (FAR_LOAD && FAR_SEG == 2'(s)) begin
          seg_q[s] <= FAR_PTR[31:16]; // RULE17
        end else if (REG_WR && REG_ADDR == REG_SEG0 + 5'(s)) begin
          seg_q[s] <= REG_WDATA;
        end
      end
    end
  endgenerate

  // instruction pointer: offset within the code segment
  always_ff @(posedge CLK) begin
    if (RESET) begin
      ip_q <= IP_RESET;
    end else if (FAR_LOAD && FAR_SEG == CFSA_SEG_CODE) begin
      ip_q <= FAR_PTR[15:0]; // RULE17
    end else if (REG_WR && REG_ADDR == REG_IP) begin
      ip_q <= REG_WDATA; // RULE16
    end else if (IP_ADVANCE) begin
      ip_q <= ip_q + {13'h0000, IP_STEP}; // RULE16
    end
  end

  // physical address: offset is only 16 bits wide so a segment never
  // reaches past 64K; the sum drops its carry and wraps at 1M
  cfsa_seg_t sel_seg;
  logic [15:0] off;
  logic [PHYS_AW-1:0] phys_d;
  always_comb begin
    sel_seg = cfsa_pick_seg(REF_KIND, USE_FRAME_BASE, OVR_VALID, OVR_SEG); // RULE3
    off = (REF_KIND == CFSA_REF_FETCH) ? ip_q : ADDR_OFFSET; // RULE2 RULE16
    phys_d = PHYS_AW'({seg_q[sel_seg], 4'h0} + {4'h0, off}); // RULE1 RULE22
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      PHYS_ADDR <= 20'h00000;
    end else if (ADDR_EN) begin
      PHYS_ADDR <= phys_d; // RULE1
    end
  end

  // queue mode strap: read pin sampled in the first cycle after reset
  always_ff @(posedge CLK) begin
    if (RESET) begin
      queue_mode_q <= 1'b0;
      strap_done_q <= 1'b0;
    end else if (!strap_done_q) begin
      queue_mode_q <= !READ_PIN_I; // RULE20
      strap_done_q <= 1'b1;
    end
  end

  // pin mux: strobes or queue status; write pin floats in hold and reset
  always_ff @(posedge CLK) begin
    if (RESET) begin
      ALE_QS0 <= 1'b0;
      WR_QS1_O <= 1'b1;
      WR_QS1_OE <= 1'b0; // RULE21
    end else if (queue_mode_q) begin
      ALE_QS0 <= QUEUE_EVENT[0]; // RULE18 RULE19
      WR_QS1_O <= QUEUE_EVENT[1]; // RULE18 RULE19
      WR_QS1_OE <= !BUS_HOLD; // RULE21
    end else begin
      ALE_QS0 <= ALE_REQ && !BUS_HOLD;
      WR_QS1_O <= !WRITE_REQ; // RULE21
      WR_QS1_OE <= !BUS_HOLD; // RULE21
    end
  end

  // register read, one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge CLK) begin
    if (RESET) begin
      REG_RDATA <= 16'h0000;
    end else if (REG_RD) begin
      if (REG_ADDR <= 5'h07) begin
        REG_RDATA <= gen_q[REG_ADDR[2:0]];
      end else if (REG_ADDR <= 5'h0b) begin
        REG_RDATA <= seg_q[REG_ADDR[1:0]];
      end else if (REG_ADDR == REG_IP) begin
        REG_RDATA <= ip_q;
      end else if (REG_ADDR == REG_FLAGS) begin
        REG_RDATA <= flags_q;
      end else if (REG_ADDR == REG_MODE) begin
        REG_RDATA <= {15'h0000, queue_mode_q};
      end else if (REG_ADDR[4:3] == 2'b10) begin
        REG_RDATA <= {8'h00, REG_ADDR[2] ? gen_q[REG_ADDR[1:0]][15:8]
                                        : gen_q[REG_ADDR[1:0]][7:0]};
      end else begin
        REG_RDATA <= 16'h0000;
      end
    end else begin
      REG_RDATA <= 16'h0000;
    end
  end

endmodule : cfsa_core
`default_nettype wire

// ### tb/cfsa_core_assertions.sv
/*
  checker for the core: pin muxing, interrupt and trap pulses, flags word
  fixed bits and address hold.
  assumes one clock and a synchronous active-high reset; bound to the core.
*/
`timescale 1ns/1ps
`default_nettype none
module cfsa_chk
  import cfsa_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // register port
  input wire logic [4:0] REG_ADDR,
  input wire logic REG_RD,
  input wire logic [15:0] REG_RDATA,
  // address and events
  input wire logic ADDR_EN,
  input wire logic [19:0] PHYS_ADDR,
  input wire logic INSTR_DONE,
  input wire logic MASK_IRQ,
  input wire logic TRAP_STEP,
  input wire logic TAKE_IRQ,
  // pins
  input wire logic [1:0] QUEUE_EVENT,
  input wire logic BUS_HOLD,
  input wire logic ALE_REQ,
  input wire logic WRITE_REQ,
  input wire logic READ_PIN_I,
  input wire logic ALE_QS0,
  input wire logic WR_QS1_O,
  input wire logic WR_QS1_OE
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RESET);
  logic rel_q;
  logic known_q;
  logic qm_q;
  // strap mirror; pins other than the hold float check are only judged once the mode is known
  always_ff @(posedge CLK) begin
    rel_q <= RESET;
  end
  always_ff @(posedge CLK) begin
    if (RESET) known_q <= 1'b0;
    else if (rel_q) known_q <= 1'b1;
  end
  always_ff @(posedge CLK) begin
    if (!RESET && rel_q) qm_q <= !READ_PIN_I;
  end
  flags_fixed_a:
  assert property (REG_RD && REG_ADDR == REG_FLAGS |=>
    (REG_RDATA & ~FLAGS_WR_MASK) == FLAGS_FIXED) else $error("flags fixed bits wrong");
  addr_hold_a:
  assert property (!ADDR_EN |=> $stable(PHYS_ADDR)) else $error("address moved");
  irq_cause_a:
  assert property (TAKE_IRQ |-> $past(INSTR_DONE && MASK_IRQ)) else $error("irq without cause");
  trap_cause_a:
  assert property (TRAP_STEP |-> $past(INSTR_DONE)) else $error("trap off boundary");
  trap_once_a:
  assert property (TRAP_STEP |=> !TRAP_STEP [*3]) else $error("trap repeated");
  wr_float_a:
  assert property (BUS_HOLD |=> !WR_QS1_OE) else $error("write pin driven in hold");
  wr_drive_a:
  assert property (known_q && !BUS_HOLD |=> WR_QS1_OE) else $error("write pin not driven");
  strobe_pins_a:
  assert property (known_q && !qm_q && !BUS_HOLD |=>
    ALE_QS0 == $past(ALE_REQ) && WR_QS1_O == !$past(WRITE_REQ)) else $error("strobe pins wrong");
  queue_pins_a:
  assert property (known_q && qm_q && !BUS_HOLD |=>
    {WR_QS1_O, ALE_QS0} == $past(QUEUE_EVENT)) else $error("queue pins wrong");
endmodule : cfsa_chk
bind cfsa_core cfsa_chk chk_i (.*);
`default_nettype wire

// ### tb/cfsa_bus_model.sv
/*
  far side model: read pin strap with its pull-up, and a queue tracker
  that tallies status codes seen on the two status pins.
  assumes the core's clock and reset.
*/
`timescale 1ns/1ps
`default_nettype none
module cfsa_bus_model (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // strap choice
  input wire logic strap_low,
  // core pins
  input wire logic ale_pin,
  input wire logic wr_o,
  input wire logic wr_oe,
  output logic rd_pin,
  // tallies
  output logic [3:0] n_first,
  output logic [3:0] n_next,
  output logic [3:0] n_flush
);
  logic [1:0] age_q;
  logic wr_last_q;
  logic wr_pin;
  // pulled up in reset, grounded after it only when strap_low is set, to ask for queue status
  assign rd_pin = (reset || !strap_low) ? 1'b1 : 1'b0;
  // nothing pulls the write pin, so a float shows a changing level
  assign wr_pin = wr_oe ? wr_o : !wr_last_q;
  always_ff @(posedge clk) begin
    wr_last_q <= wr_pin;
  end
  // mode reaches the pins two edges after release
  always_ff @(posedge clk) begin
    if (reset) age_q <= 2'h0;
    else if (age_q != 2'h3) age_q <= age_q + 2'h1;
  end
  // tally the first, next and flush codes while queue status is on the pins
  always_ff @(posedge clk) begin
    if (reset) begin
      {n_first, n_next, n_flush} <= 12'h000;
    end else if (strap_low && wr_oe && age_q == 2'h3) begin
      case ({wr_pin, ale_pin})
        2'b01: n_first <= n_first + 4'h1;
        2'b11: n_next <= n_next + 4'h1;
        2'b10: n_flush <= n_flush + 4'h1;
        default: ;
      endcase
    end
  end
endmodule : cfsa_bus_model
`default_nettype wire

// ### tb/cpu_flags_segment_addressing_test.sv
/*
  testbench: flag and address rows, then registers, strings, interrupts,
  trap, strobe pins and queue status mode after a second reset.
  assumes the core, its package, the checker and the bus model.
*/
`timescale 1ns/1ps
`default_nettype none
module cpu_flags_segment_addressing_test;
  import cfsa_pkg::*;
  typedef struct packed {
    logic ad;
    logic [1:0] op;
    logic by;
    logic ci;
    logic [15:0] a;
    logic [15:0] b;
    logic [19:0] ex;
  } cfsa_row_t;
  // design inputs
  logic CLK = 1'b0;
  logic RESET = 1'b1;
  logic [4:0] REG_ADDR = 5'h00;
  logic [15:0] REG_WDATA = 16'h0000, ALU_A = 16'h0000, ALU_B = 16'h0000, ADDR_OFFSET = 16'h0000;
  logic REG_WR = 1'b0, REG_RD = 1'b0, ALU_BYTE = 1'b0, ALU_CIN = 1'b0, STR_WORD = 1'b0;
  logic [1:0] ALU_OP = 2'h0, REF_KIND = 2'h0, OVR_SEG = 2'h0, FAR_SEG = 2'h0, QUEUE_EVENT = 2'h0;
  logic USE_FRAME_BASE = 1'b0, OVR_VALID = 1'b0, MASK_IRQ = 1'b0, BUS_HOLD = 1'b0;
  logic ALE_REQ = 1'b0, WRITE_REQ = 1'b0, strap = 1'b0;
  logic [2:0] ALU_DEST = 3'h3, IP_STEP = 3'h3;
  logic [31:0] FAR_PTR = 32'h00000000;
  logic [5:0] ev = 6'h00;
  // event strobes share one vector so a single task pulses any of them
  wire logic ALU_EN = ev[0];
  wire logic ADDR_EN = ev[1];
  wire logic IP_ADVANCE = ev[2];
  wire logic FAR_LOAD = ev[3];
  wire logic STR_STEP = ev[4];
  wire logic INSTR_DONE = ev[5];
  wire logic READ_PIN_I;
  logic [15:0] REG_RDATA;
  logic [19:0] PHYS_ADDR;
  logic TRAP_STEP, TAKE_IRQ, ALE_QS0, WR_QS1_O, WR_QS1_OE;
  logic [3:0] n_first, n_next, n_flush;
  int err_count = 0, cmp_count = 0, cyc = 0;
  logic [15:0] segv [4] = '{16'h1000, 16'h0100, 16'h2000, 16'hffff};
  logic [1:0] qseq [5] = '{2'h1, 2'h3, 2'h3, 2'h2, 2'h0};
  cfsa_row_t rows [15] = '{
    '{1'h0, 2'h0, 1'h0, 1'h0, 16'hffff, 16'h0001, 20'h00055},
    '{1'h0, 2'h0, 1'h0, 1'h0, 16'h7fff, 16'h0001, 20'h00894},
    '{1'h0, 2'h1, 1'h0, 1'h0, 16'h0000, 16'h0001, 20'h00095},
    '{1'h0, 2'h0, 1'h1, 1'h0, 16'h0080, 16'h0080, 20'h00845},
    '{1'h0, 2'h2, 1'h0, 1'h0, 16'hffff, 16'h8001, 20'h00080},
    '{1'h0, 2'h1, 1'h0, 1'h1, 16'h0003, 16'h0001, 20'h00000},
    '{1'h0, 2'h3, 1'h0, 1'h0, 16'hffff, 16'h0001, 20'h00000},
    '{1'h0, 2'h1, 1'h1, 1'h0, 16'h0010, 16'h0001, 20'h00014},
    '{1'h1, 2'h0, 1'h1, 1'h0, 16'h0050, 16'h0003, 20'h01000},
    '{1'h1, 2'h1, 1'h0, 1'h0, 16'h0004, 16'h0000, 20'h20004},
    '{1'h1, 2'h2, 1'h0, 1'h0, 16'hffff, 16'h0000, 20'h1ffff},
    '{1'h1, 2'h3, 1'h0, 1'h0, 16'h0020, 16'h0000, 20'h00010},
    '{1'h1, 2'h3, 1'h0, 1'h1, 16'h0030, 16'h0000, 20'h20030},
    '{1'h1, 2'h3, 1'h1, 1'h0, 16'h0005, 16'h0000, 20'h10005},
    '{1'h1, 2'h1, 1'h1, 1'h0, 16'h0002, 16'h0001, 20'h01002}};
  cfsa_core dut (.*);
  cfsa_bus_model partner (.clk(CLK), .reset(RESET), .strap_low(strap), .ale_pin(ALE_QS0),
    .wr_o(WR_QS1_O), .wr_oe(WR_QS1_OE), .rd_pin(READ_PIN_I), .n_first(n_first),
    .n_next(n_next), .n_flush(n_flush));
  // 40 MHz clock
  always #12.5 CLK = ~CLK;
  task results;
    if (err_count == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results
  task chk(input logic [19:0] g, input logic [19:0] e);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("mismatch at %0t: got %h exp %h", $time, g, e);
    end
  endtask : chk
  task tick;
    @(posedge CLK);
  endtask : tick
  // outputs read after an edge are the values that stood in the cycle before it
  task pulse(input logic [5:0] m);
    ev <= m;
    tick();
    ev <= 6'h00;
    tick();
  endtask : pulse
  task wr(input logic [4:0] a, input logic [15:0] d);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    tick();
    REG_WR <= 1'b0;
    tick();
  endtask : wr
  task rd(input logic [4:0] a, input logic [15:0] m, input logic [15:0] e);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    tick();
    REG_RD <= 1'b0;
    tick();
    chk({4'h0, REG_RDATA & m}, {4'h0, e});
  endtask : rd
  // hang guard, the run needs well under a thousand cycles
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      results();
    end
  end
  initial begin
    repeat (3) tick();
    chk(20'(WR_QS1_OE), 20'h00000);
    repeat (2) tick();
    RESET <= 1'b0;
    tick();
    rd(REG_FLAGS, 16'hffff, FLAGS_RESET);
    rd(REG_SEG0 + 5'h1, 16'hffff, CODE_SEG_RESET);
    rd(REG_IP, 16'hffff, IP_RESET);
    rd(REG_MODE, 16'h0001, 16'h0000);
    wr(REG_FLAGS, 16'hffff);
    rd(REG_FLAGS, 16'hffff, FLAGS_WR_MASK | FLAGS_FIXED);
    wr(REG_FLAGS, 16'h0000);
    foreach (segv[i]) wr(REG_SEG0 + 5'(i), segv[i]);
    foreach (rows[i]) begin
      {ALU_OP, ALU_BYTE, ALU_CIN} <= {rows[i].op, rows[i].by, rows[i].ci};
      {ALU_A, ALU_B} <= {rows[i].a, rows[i].b};
      {REF_KIND, OVR_VALID, USE_FRAME_BASE} <= {rows[i].op, rows[i].by, rows[i].ci};
      ADDR_OFFSET <= rows[i].a;
      OVR_SEG <= rows[i].b[1:0];
      pulse(rows[i].ad ? 6'h02 : 6'h01);
      if (rows[i].ad) chk(PHYS_ADDR, rows[i].ex);
      else rd(REG_FLAGS, 16'h08d5, rows[i].ex[15:0]);
    end
    // the alu rows except the pass row write back into the base word; last one is a byte sub
    rd(REG_GEN0 + 5'h3, 16'hffff, 16'h000f);
    FAR_PTR <= 32'h12340010;
    FAR_SEG <= 2'h1;
    REF_KIND <= 2'h0;
    pulse(6'h08);
    pulse(6'h02);
    chk(PHYS_ADDR, 20'h12350);
    pulse(6'h04);
    pulse(6'h02);
    chk(PHYS_ADDR, 20'h12353);
    wr(REG_BYTE0 + 5'h4, 16'h00ab);
    wr(REG_BYTE0, 16'h00cd);
    rd(REG_GEN0, 16'hffff, 16'habcd);
    rd(REG_BYTE0 + 5'h4, 16'hffff, 16'h00ab);
    wr(5'h06, 16'h0010);
    wr(5'h07, 16'h0020);
    STR_WORD <= 1'b1;
    pulse(6'h10);
    rd(5'h06, 16'hffff, 16'h0012);
    rd(5'h07, 16'hffff, 16'h0022);
    wr(REG_FLAGS, 16'h0400);
    STR_WORD <= 1'b0;
    pulse(6'h10);
    rd(5'h06, 16'hffff, 16'h0011);
    MASK_IRQ <= 1'b1;
    wr(REG_FLAGS, 16'h0000);
    pulse(6'h20);
    chk(20'(TAKE_IRQ), 20'h00000);
    wr(REG_FLAGS, 16'h0200);
    pulse(6'h20);
    chk(20'(TAKE_IRQ), 20'h00001);
    MASK_IRQ <= 1'b0;
    wr(REG_FLAGS, 16'h0100);
    pulse(6'h20);
    pulse(6'h20);
    chk(20'(TRAP_STEP), 20'h00001);
    rd(REG_FLAGS, 16'h0100, 16'h0000);
    ALE_REQ <= 1'b1;
    WRITE_REQ <= 1'b1;
    repeat (2) tick();
    chk(20'({ALE_QS0, WR_QS1_O, WR_QS1_OE}), 20'h00005);
    {ALE_REQ, WRITE_REQ, BUS_HOLD} <= 3'b001;
    repeat (2) tick();
    chk(20'(WR_QS1_OE), 20'h00000);
    {BUS_HOLD, RESET, strap} <= 3'b011;
    repeat (5) tick();
    RESET <= 1'b0;
    repeat (4) tick();
    rd(REG_MODE, 16'h0001, 16'h0001);
    foreach (qseq[i]) begin
      QUEUE_EVENT <= qseq[i];
      tick();
      if (i > 0) chk(20'({WR_QS1_O, ALE_QS0}), 20'(qseq[i - 1]));
    end
    repeat (2) tick();
    chk(20'({n_first, n_next, n_flush}), 20'h00121);
    results();
  end
endmodule : cpu_flags_segment_addressing_test
`default_nettype wire
